// ===== dos_pkg.sv
// constants, register map and state type of the drive operating-state sequencer
package dos_pkg;

  // ==========================================================
  // register bus
  localparam int          AW             = 5;
  localparam int          DW             = 32;
  localparam logic [4:0]  ADDR_CTRL      = 5'h00;
  localparam logic [4:0]  ADDR_STATUS    = 5'h04;
  localparam logic [4:0]  ADDR_MODE      = 5'h08;
  localparam logic [4:0]  ADDR_REF       = 5'h0c;
  localparam logic [4:0]  ADDR_CFG       = 5'h10;
  localparam logic [4:0]  ADDR_ADJ       = 5'h14;
  localparam logic [4:0]  ADDR_TUNE      = 5'h18;
  localparam logic [4:0]  ADDR_FUNC      = 5'h1c;

  // ==========================================================
  // control word bits (standard profile; CW_RUN is the i/o profile run bit)
  localparam int          CW_SWITCH_ON   = 0;
  localparam int          CW_EN_VOLT     = 1;
  localparam int          CW_QSTOP_N     = 2;
  localparam int          CW_EN_OP       = 3;
  localparam int          CW_FAULT_RST   = 7;
  localparam int          CW_HALT        = 8;
  localparam int          CW_RUN         = 0;
  localparam int          CW_STD_FUNC_LO = 11;

  // ==========================================================
  // mode register fields
  localparam int          MODE_IO        = 0;
  localparam int          MODE_SEPARATE  = 1;
  localparam int          MODE_DIS_STOP  = 2;
  localparam int          MODE_QS_HOLD   = 3;
  localparam int          MODE_SEP_STAGE = 4;
  localparam logic [4:0]  MODE_RESET     = 5'h00;

  // ==========================================================
  // status register fields
  localparam int          ST_CFG_REJ     = 4;
  localparam int          ST_REF_SEEN    = 5;
  localparam int          ST_TUNE        = 6;

  localparam logic [3:0]  CODE_SWONDIS   = 4'h2;
  localparam logic [3:0]  CODE_READY     = 4'h3;
  localparam logic [3:0]  CODE_SWON      = 4'h4;
  localparam logic [3:0]  CODE_OPEN      = 4'h5;
  localparam logic [3:0]  CODE_QSTOP     = 4'h6;
  localparam logic [3:0]  CODE_FREACT    = 4'h7;
  localparam logic [3:0]  CODE_FAULT     = 4'h8;

  typedef enum logic [2:0] {
    DOS_INIT, DOS_SWONDIS, DOS_READY, DOS_SWON,
    DOS_OPEN, DOS_QSTOP, DOS_FREACT, DOS_FAULT
  } dos_state_e;

endpackage

// ===== dos_state_machine.sv
// operating-state sequencer of a variable speed drive with an Avalon-MM register slave
// Functional notes
// - i/o profile: control bits 1..15 each drive one function output
// - i/o profile: run bit starts the drive at once, no sequence needed
// - standard profile: drive starts only after the command sequence steps
// - standard profile: only control bits 11..15 map to function outputs
// - separate / not-separate mode selects how command and reference are sourced
// - state changes on a control word or on an internal error event
// - status word reports the current operating state code
// - initialisation state is transient and never reported
// - state 2: power stage off, motor unpowered, contactor open, all params writable
// - state 3: motor off; separate stage needs supply before state 4
// - state 4: power stage and contactor on, no motor voltage, adjust only
// - configuration write in state 4 falls back to state 2
// - state 5: motor powered, functions on, configuration writes rejected
// - running with zero reference or halt: no power, no torque
// - self-tuning runs only in state 5
// - enable operation needs valid channel and, if shared, a reference once
// - disable operation with select 0: straight to state 4, coasting
// - disable operation with select 1: ramp down, then state 4
// - quick stop on fast ramp, then state 2 or hold until disable voltage
// - fault reaction is transient, then fault with power stage off
//
// The address map and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module dos_state_machine
  import dos_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    nrst,
  input  wire logic [dos_pkg::AW-1:0]  address,
  input  wire logic                    read,
  input  wire logic                    write,
  input  wire logic [dos_pkg::DW-1:0]  writedata,
  output logic      [dos_pkg::DW-1:0]  readdata,
  output logic                         waitrequest,
  input  wire logic                    powerOk,
  input  wire logic                    chanValid,
  input  wire logic                    errorDetect,
  input  wire logic                    motorStopped,
  output logic                         powerStageOn,
  output logic                         contactorClose,
  output logic                         motorPowered,
  output logic                         driveFuncEn,
  output logic                         decelRamp,
  output logic                         fastRamp,
  output logic                         coastStop,
  output logic                         tuneActive,
  output logic      [14:0]             funcOut
);
  import dos_pkg::*;

  // ==========================================================
  // bus slave
  dos_state_e  state;
  logic [15:0] ctrlWord;
  logic [4:0]  modeReg;
  logic [15:0] refValue;
  logic [15:0] cfgParam;
  logic [15:0] adjParam;
  logic        refSeen;
  logic        cfgReject;
  logic        tuneReq;
  logic        rampActive;
  logic        prevFaultRst;
  logic [3:0]  stCode;

  logic        wrAcc;
  logic        cfgWrite;
  assign wrAcc    = write && !waitrequest;
  assign cfgWrite = wrAcc && (address == ADDR_CFG);

  // one wait cycle per access keeps read data settled before it is taken
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      waitrequest <= 1'b1;
    end else if ((read || write) && waitrequest) begin
      waitrequest <= 1'b0;
    end else begin
      waitrequest <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      readdata <= 32'h0000_0000;
    end else if (read && waitrequest) begin
      case (address)
        ADDR_CTRL:   readdata <= {16'h0000, ctrlWord};
        ADDR_STATUS: readdata <= {25'h0, tuneActive, refSeen, cfgReject, stCode};
        ADDR_MODE:   readdata <= {27'h0, modeReg};
        ADDR_REF:    readdata <= {16'h0000, refValue};
        ADDR_CFG:    readdata <= {16'h0000, cfgParam};
        ADDR_ADJ:    readdata <= {16'h0000, adjParam};
        ADDR_TUNE:   readdata <= {31'h0, tuneReq};
        ADDR_FUNC:   readdata <= {17'h0, funcOut};
        default:     readdata <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // software registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrlWord <= 16'h0000;
      modeReg  <= MODE_RESET;
      refValue <= 16'h0000;
      adjParam <= 16'h0000;
      refSeen  <= 1'b0;
    end else if (wrAcc) begin
      case (address)
        ADDR_CTRL: ctrlWord <= writedata[15:0];
        ADDR_MODE: modeReg  <= writedata[4:0];
        ADDR_REF: begin
          refValue <= writedata[15:0];
          refSeen  <= 1'b1;
        end
        ADDR_ADJ:  adjParam <= writedata[15:0];
        default:   ;
      endcase
    end
  end

  logic ioMode;
  logic sepMode;
  logic sepStage;
  assign ioMode   = modeReg[MODE_IO];
  assign sepMode  = modeReg[MODE_SEPARATE];
  assign sepStage = modeReg[MODE_SEP_STAGE];

  function automatic logic cfgAllowed(input dos_state_e s);
    cfgAllowed = (s == DOS_SWONDIS) || (s == DOS_READY) ||
                 (s == DOS_SWON) || (s == DOS_FAULT);
  endfunction

  function automatic logic stageOn(input dos_state_e s);
    stageOn = (s == DOS_SWON) || (s == DOS_OPEN) || (s == DOS_QSTOP);
  endfunction

  // rejected configuration writes leave the old value in place
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cfgParam <= 16'h0000;
    end else if (cfgWrite && cfgAllowed(state)) begin
      cfgParam <= writedata[15:0];
    end
  end

  // sticky reject flag: a new reject wins over a write-one clear
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cfgReject <= 1'b0;
    end else if (cfgWrite && !cfgAllowed(state)) begin
      cfgReject <= 1'b1;
    end else if (wrAcc && address == ADDR_STATUS && writedata[ST_CFG_REJ]) begin
      cfgReject <= 1'b0;
    end
  end

  // ==========================================================
  // command decode
  logic disVolt;
  logic quickStop;
  logic shutdown;
  logic switchOn;
  logic enableOp;
  logic faultRstEdge;
  logic runCmd;
  logic haltCmd;
  assign disVolt      = !ctrlWord[CW_EN_VOLT];
  assign quickStop    = ctrlWord[CW_EN_VOLT] && !ctrlWord[CW_QSTOP_N];
  assign shutdown     = ctrlWord[2:0] == 3'b110;
  assign switchOn     = ctrlWord[3:0] == 4'b0111;
  assign enableOp     = ctrlWord[3:0] == 4'b1111;
  assign faultRstEdge = ctrlWord[CW_FAULT_RST] && !prevFaultRst;
  assign runCmd       = ctrlWord[CW_RUN];
  assign haltCmd      = !ioMode && ctrlWord[CW_HALT];

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prevFaultRst <= 1'b0;
    end else begin
      prevFaultRst <= ctrlWord[CW_FAULT_RST];
    end
  end

  // ==========================================================
  // operating state
  logic errTake;
  logic refReady;
  assign errTake  = errorDetect && (state != DOS_INIT) &&
                    (state != DOS_FREACT) && (state != DOS_FAULT);
  assign refReady = sepMode || refSeen;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state      <= DOS_INIT;
      rampActive <= 1'b0;
    end else if (errTake) begin
      state      <= DOS_FREACT;
      rampActive <= 1'b0;
    end else if (state == DOS_SWON && cfgWrite) begin
      state <= DOS_SWONDIS;
    end else begin
      case (state)
        DOS_INIT: state <= DOS_SWONDIS;
        DOS_SWONDIS: begin
          if (ioMode) begin
            if (runCmd && powerOk) state <= DOS_OPEN;
          end else if (shutdown) begin
            state <= DOS_READY;
          end
        end
        DOS_READY: begin
          if (ioMode || disVolt || quickStop) begin
            state <= DOS_SWONDIS;
          end else if ((switchOn || enableOp) && (!sepStage || powerOk)) begin
            state <= DOS_SWON;
          end
        end
        DOS_SWON: begin
          if (ioMode || disVolt || quickStop) begin
            state <= DOS_SWONDIS;
          end else if (shutdown && !ctrlWord[CW_SWITCH_ON]) begin
            state <= DOS_READY;
          end else if (enableOp && chanValid && refReady) begin
            state <= DOS_OPEN;
          end
        end
        DOS_OPEN: begin
          if (ioMode) begin
            if (!runCmd) rampActive <= 1'b1;
            if (rampActive && motorStopped) begin
              state      <= DOS_SWONDIS;
              rampActive <= 1'b0;
            end else if (runCmd) begin
              rampActive <= 1'b0;
            end
          end else if (disVolt) begin
            state      <= DOS_SWONDIS;
            rampActive <= 1'b0;
          end else if (quickStop) begin
            state      <= DOS_QSTOP;
            rampActive <= 1'b0;
          end else if (shutdown && !ctrlWord[CW_SWITCH_ON]) begin
            state      <= DOS_READY;
            rampActive <= 1'b0;
          end else if (switchOn) begin
            if (!modeReg[MODE_DIS_STOP]) begin
              state <= DOS_SWON;
            end else if (rampActive && motorStopped) begin
              state      <= DOS_SWON;
              rampActive <= 1'b0;
            end else begin
              rampActive <= 1'b1;
            end
          end else begin
            rampActive <= 1'b0;
          end
        end
        DOS_QSTOP: begin
          if (disVolt) begin
            state <= DOS_SWONDIS;
          end else if (motorStopped && !modeReg[MODE_QS_HOLD]) begin
            state <= DOS_SWONDIS;
          end
        end
        DOS_FREACT: if (motorStopped) state <= DOS_FAULT;
        DOS_FAULT:  if (faultRstEdge) state <= DOS_SWONDIS;
        default:    state <= DOS_INIT;
      endcase
    end
  end

  // status code never shows initialisation
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stCode <= CODE_SWONDIS;
    end else begin
      case (state)
        DOS_SWONDIS: stCode <= CODE_SWONDIS;
        DOS_READY:   stCode <= CODE_READY;
        DOS_SWON:    stCode <= CODE_SWON;
        DOS_OPEN:    stCode <= CODE_OPEN;
        DOS_QSTOP:   stCode <= CODE_QSTOP;
        DOS_FREACT:  stCode <= CODE_FREACT;
        DOS_FAULT:   stCode <= CODE_FAULT;
        default:     stCode <= stCode;
      endcase
    end
  end

  // ==========================================================
  // self-tuning: a request outside state 5 is not stored
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tuneReq    <= 1'b0;
      tuneActive <= 1'b0;
    end else begin
      if (state != DOS_OPEN) begin
        tuneReq <= 1'b0;
      end else if (wrAcc && address == ADDR_TUNE) begin
        tuneReq <= writedata[0];
      end
      tuneActive <= (state == DOS_OPEN) && tuneReq;
    end
  end

  // ==========================================================
  // power outputs, one cycle behind the state
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      powerStageOn   <= 1'b0;
      contactorClose <= 1'b0;
      motorPowered   <= 1'b0;
      driveFuncEn    <= 1'b0;
      decelRamp      <= 1'b0;
      fastRamp       <= 1'b0;
      coastStop      <= 1'b0;
    end else begin
      powerStageOn   <= stageOn(state);
      contactorClose <= stageOn(state);
      motorPowered   <= (state == DOS_OPEN && (rampActive ||
                         (refValue != 16'h0000 && !haltCmd))) ||
                        (state == DOS_QSTOP && !motorStopped) ||
                        (state == DOS_FREACT && !motorStopped);
      driveFuncEn    <= state == DOS_OPEN;
      decelRamp      <= state == DOS_OPEN && rampActive;
      fastRamp       <= state == DOS_QSTOP || state == DOS_FREACT;
      coastStop      <= state == DOS_SWON || state == DOS_SWONDIS ||
                        state == DOS_READY || state == DOS_FAULT;
    end
  end

  // ==========================================================
  // function outputs
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      funcOut <= 15'h0000;
    end else if (ioMode) begin
      funcOut <= ctrlWord[15:1];
    end else begin
      funcOut <= {ctrlWord[15:CW_STD_FUNC_LO], 10'h000};
    end
  end

  // ==========================================================
  // checks
  init_leave_a: assert property (@(posedge clk) disable iff (!nrst)
    state == DOS_INIT && nrst |=> state == DOS_SWONDIS)
    else $error("init did not move to switch on disabled");

  init_hidden_a: assert property (@(posedge clk) disable iff (!nrst)
    stCode != 4'h1 && stCode != 4'h0)
    else $error("status shows initialisation");

  swondis_off_a: assert property (@(posedge clk) disable iff (!nrst)
    state == DOS_SWONDIS ##1 state == DOS_SWONDIS |-> !powerStageOn && !contactorClose)
    else $error("power stage on in switch on disabled");

  stage_supply_a: assert property (@(posedge clk) disable iff (!nrst)
    state == DOS_READY && sepStage && !powerOk |=> state != DOS_SWON)
    else $error("switched on without power stage supply");

  cfg_fallback_a: assert property (@(posedge clk) disable iff (!nrst)
    state == DOS_SWON && cfgWrite && !errorDetect |=> state == DOS_SWONDIS)
    else $error("config write in state 4 did not fall back");

  cfg_reject_a: assert property (@(posedge clk) disable iff (!nrst)
    state == DOS_OPEN && cfgWrite |=> cfgReject && $stable(cfgParam))
    else $error("config write accepted while running");

  halt_power_a: assert property (@(posedge clk) disable iff (!nrst)
    state == DOS_OPEN && !rampActive && (haltCmd || refValue == 16'h0000)
    |=> !motorPowered)
    else $error("motor powered with halt or zero reference");

  tune_state_a: assert property (@(posedge clk) disable iff (!nrst)
    tuneActive |-> $past(state) == DOS_OPEN)
    else $error("tuning outside operation enabled");

  ref_needed_a: assert property (@(posedge clk) disable iff (!nrst)
    state == DOS_SWON && !ioMode && (!refReady || !chanValid) |=> state != DOS_OPEN)
    else $error("enabled without valid channel or reference");

  coast_direct_a: assert property (@(posedge clk) disable iff (!nrst)
    state == DOS_OPEN && !ioMode && switchOn && !modeReg[MODE_DIS_STOP] && !errorDetect
    |=> state == DOS_SWON ##1 !motorPowered)
    else $error("disable operation select 0 did not coast to state 4");

  react_end_a: assert property (@(posedge clk) disable iff (!nrst)
    state == DOS_FREACT && motorStopped |=> state == DOS_FAULT ##1 !powerStageOn)
    else $error("fault reaction did not end in fault");

  io_start_a: assert property (@(posedge clk) disable iff (!nrst)
    state == DOS_SWONDIS && ioMode && runCmd && powerOk && !errorDetect
    |=> state == DOS_OPEN)
    else $error("i/o profile run did not start the drive");

  run_reached_c: cover property (@(posedge clk) disable iff (!nrst)
    state == DOS_SWON ##1 state == DOS_OPEN);
  qstop_seen_c: cover property (@(posedge clk) disable iff (!nrst)
    state == DOS_QSTOP ##[1:50] state == DOS_SWONDIS);
  fault_seen_c: cover property (@(posedge clk) disable iff (!nrst)
    state == DOS_FREACT ##[1:50] state == DOS_FAULT);
  ramp_stop_c: cover property (@(posedge clk) disable iff (!nrst)
    decelRamp ##[1:50] state == DOS_SWON);

endmodule

`default_nettype wire

// ===== dos_plc_model.sv
// bus master model standing in for the fieldbus controller of the drive
`timescale 1ns/1ps
`default_nettype none

module dos_plc_model
  import dos_pkg::*;
(
  input  wire logic                    clk,
  output logic      [dos_pkg::AW-1:0]  address,
  output logic                         read,
  output logic                         write,
  output logic      [dos_pkg::DW-1:0]  writedata,
  input  wire logic [dos_pkg::DW-1:0]  readdata,
  input  wire logic                    waitrequest
);
  import dos_pkg::*;

  initial begin
    address   = '0;
    read      = 1'b0;
    write     = 1'b0;
    writedata = '0;
  end

  // ==========================================================
  // one access, held until waitrequest is seen low at an edge
  task automatic access(input logic isWr, input logic [AW-1:0] a, input logic [DW-1:0] d,
                        output logic [DW-1:0] q);
    @(posedge clk);
    address   <= a;
    writedata <= d;
    write     <= isWr;
    read      <= ~isWr;
    do begin
      @(posedge clk);
    end while (waitrequest !== 1'b0);
    q = readdata;
    write     <= 1'b0;
    read      <= 1'b0;
    // released lines carry junk so nothing leans on a stale value
    address   <= ~a;
    writedata <= ~d;
  endtask

  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    logic [DW-1:0] q;
    access(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] q);
    access(1'b0, a, '0, q);
  endtask

  // ==========================================================
  // controller start-up: shutdown, switch on, enable operation
  task automatic toRun();
    wr(ADDR_CTRL, 32'h0000_0006);
    wr(ADDR_CTRL, 32'h0000_0007);
    wr(ADDR_CTRL, 32'h0000_000f);
  endtask
endmodule

`default_nettype wire

// ===== test_drive_operating_state_machine.sv
// self-checking testbench of the drive operating-state sequencer
`timescale 1ns/1ps
`default_nettype none

module test_drive_operating_state_machine;
  import dos_pkg::*;

  logic          clk, nrst, powerOk, chanValid, errorDetect, motorStopped;
  logic [AW-1:0] address;
  logic          read, write, waitrequest;
  logic [DW-1:0] writedata, readdata, rdData;
  logic          powerStageOn, contactorClose, motorPowered, driveFuncEn;
  logic          decelRamp, fastRamp, coastStop, tuneActive;
  logic [14:0]   funcOut;
  int            err_total = 0;
  int            tests_run = 0;
  int            cycles = 0;

  dos_state_machine dos_state_machine_inst (
    .clk(clk), .nrst(nrst), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .powerOk(powerOk), .chanValid(chanValid), .errorDetect(errorDetect),
    .motorStopped(motorStopped), .powerStageOn(powerStageOn),
    .contactorClose(contactorClose), .motorPowered(motorPowered),
    .driveFuncEn(driveFuncEn), .decelRamp(decelRamp), .fastRamp(fastRamp),
    .coastStop(coastStop), .tuneActive(tuneActive), .funcOut(funcOut)
  );

  dos_plc_model dos_plc_model_inst (
    .clk(clk), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ==========================================================
  // helpers
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    dos_plc_model_inst.wr(a, d);
  endtask

  task automatic ctrl(input logic [DW-1:0] d);
    dos_plc_model_inst.wr(ADDR_CTRL, d);
  endtask

  // state code lands two edges after the control write
  task automatic state(input logic [3:0] code);
    repeat (2) @(posedge clk);
    dos_plc_model_inst.rd(ADDR_STATUS, rdData);
    cmp({28'h0, rdData[3:0]}, {28'h0, code});
  endtask

  // power stage, contactor, motor power, functions, coasting
  task automatic outs(input logic [4:0] exp);
    cmp({27'h0, powerStageOn, contactorClose, motorPowered, driveFuncEn, coastStop},
        {27'h0, exp});
  endtask

  task automatic done(input string name);
    $display("test %s finished", name);
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // hang guard, far above the few hundred cycles the run needs
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_total++;
      wrap_up();
    end
  end

  // ==========================================================
  // test sequence
  initial begin
    nrst         = 1'b0;
    powerOk      = 1'b0;
    chanValid    = 1'b0;
    errorDetect  = 1'b0;
    motorStopped = 1'b0;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    state(CODE_SWONDIS);
    outs(5'b00001);
    dos_plc_model_inst.rd(5'h02, rdData);
    cmp(rdData, 32'h0);
    wr(ADDR_CFG, 32'h1);
    wr(ADDR_TUNE, 32'h1);
    state(CODE_SWONDIS);
    cmp({29'h0, rdData[6:4]}, 32'h0);
    done("reset");
    // separate mode with separate control stage, no supply yet
    wr(ADDR_MODE, 32'h12);
    ctrl(32'h6);
    state(CODE_READY);
    outs(5'b00001);
    ctrl(32'h7);
    state(CODE_READY);
    powerOk <= 1'b1;
    state(CODE_SWON);
    outs(5'b11001);
    wr(ADDR_ADJ, 32'h5);
    ctrl(32'hf);
    state(CODE_SWON);
    chanValid <= 1'b1;
    state(CODE_OPEN);
    outs(5'b11010);
    ctrl(32'h0);
    state(CODE_SWONDIS);
    done("separate");
    // shared channel: reference needed before running
    wr(ADDR_MODE, 32'h0);
    dos_plc_model_inst.toRun();
    state(CODE_SWON);
    wr(ADDR_REF, 32'h100);
    state(CODE_OPEN);
    outs(5'b11110);
    wr(ADDR_CFG, 32'h2);
    state(CODE_OPEN);
    cmp({26'h0, rdData[5:0]}, 32'h35);
    ctrl(32'h10f);
    state(CODE_OPEN);
    cmp({31'h0, motorPowered}, 32'h0);
    wr(ADDR_TUNE, 32'h1);
    ctrl(32'hf80f);
    state(CODE_OPEN);
    cmp({31'h0, tuneActive}, 32'h1);
    cmp({17'h0, funcOut}, 32'h7c00);
    ctrl(32'h7);
    state(CODE_SWON);
    outs(5'b11001);
    wr(ADDR_CFG, 32'h3);
    state(CODE_SWONDIS);
    done("standard");
    // ramp stop on disable operation
    wr(ADDR_MODE, 32'h4);
    dos_plc_model_inst.toRun();
    ctrl(32'h7);
    state(CODE_OPEN);
    cmp({31'h0, decelRamp}, 32'h1);
    motorStopped <= 1'b1;
    state(CODE_SWON);
    motorStopped <= 1'b0;
    ctrl(32'h0);
    done("disable");
    // quick stop: fast ramp then disable, then fast ramp then hold
    wr(ADDR_MODE, 32'h0);
    dos_plc_model_inst.toRun();
    ctrl(32'h2);
    state(CODE_QSTOP);
    cmp({31'h0, fastRamp}, 32'h1);
    motorStopped <= 1'b1;
    state(CODE_SWONDIS);
    motorStopped <= 1'b0;
    wr(ADDR_MODE, 32'h8);
    dos_plc_model_inst.toRun();
    ctrl(32'h2);
    motorStopped <= 1'b1;
    state(CODE_QSTOP);
    ctrl(32'h0);
    state(CODE_SWONDIS);
    motorStopped <= 1'b0;
    done("quickstop");
    // internal error event
    errorDetect <= 1'b1;
    @(posedge clk);
    errorDetect <= 1'b0;
    state(CODE_FREACT);
    motorStopped <= 1'b1;
    state(CODE_FAULT);
    outs(5'b00001);
    ctrl(32'h80);
    state(CODE_SWONDIS);
    motorStopped <= 1'b0;
    done("fault");
    // i/o profile: run bit alone starts, every upper bit one function
    wr(ADDR_MODE, 32'h1);
    ctrl(32'h1);
    state(CODE_OPEN);
    for (int k = 0; k < 15; k++) begin
      ctrl(32'h1 | (32'h2 << k));
      repeat (3) @(posedge clk);
      cmp({17'h0, funcOut}, 32'h1 << k);
    end
    done("ioprofile");
    wrap_up();
  end
endmodule

`default_nettype wire
